// [verilog/return_address_stack.sv]
/*
 * Return-address stack of the core: sixteen program-counter entries,
 * a five-bit pointer, overflow/underflow flags with interrupt, an
 * optional fault reset request and APB access to pointer and top entry.
 * Assumes the sequencer raises push or pop for one cycle per event and
 * that push and pop never share a cycle (push wins if they do).
 */
// Implementation choices: the register offsets and the APB interface to the registers.
module return_address_stack
    import ras_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_WIDTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_pc,
    input wire logic pop,
    output logic [WIDTH-1:0] ret_pc,
    output logic ret_valid,
    output logic fault_reset,
    output logic irq
);
    // index and field slices serve sixteen entries of fifteen bits
    if (DEPTH != STACK_DEPTH || WIDTH != PC_WIDTH) begin : g_size_check
        $error("return_address_stack: only 16 x 15 is supported");
    end

    typedef struct packed {
        // private flops, outside every program or data address space
        logic [DEPTH-1:0][WIDTH-1:0] entry;
        logic [PTR_WIDTH-1:0] ptr;
        logic [FLAG_COUNT-1:0] flags;
        logic [FLAG_COUNT-1:0] int_en;
        logic fault_cfg;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic [WIDTH-1:0] ret_pc;
        logic ret_valid;
        logic fault_reset;
        logic irq;
    } state_type;

    state_type state_q;
    state_type state_d;

    function automatic logic known_addr(input logic [ADDR_WIDTH-1:0] a);
        known_addr = (a == OFF_STACK_POINTER) || (a == OFF_TOP_ENTRY_HIGH)
            || (a == OFF_TOP_ENTRY_LOW) || (a == OFF_CONFIG)
            || (a == OFF_STATUS) || (a == OFF_INT_CLEAR)
            || (a == OFF_INT_ENABLE);
    endfunction : known_addr

    logic access;
    logic wr_take;
    logic [IDX_WIDTH-1:0] idx;
    logic do_push;
    logic do_pop;
    logic ovf_evt;
    logic unf_evt;
    logic fault_evt;
    logic [FLAG_COUNT-1:0] set_flags;
    logic [FLAG_COUNT-1:0] clr_flags;
    logic [WIDTH-1:0] top_val;

    assign access = psel && penable && !state_q.ready;
    assign wr_take = psel && penable && state_q.ready && pwrite
        && !state_q.slverr;
    assign idx = state_q.ptr[IDX_WIDTH-1:0];
    assign top_val = state_q.entry[idx];
    assign do_push = push;
    assign do_pop = pop && !push;
    assign ovf_evt = do_push && (state_q.ptr == PTR_LAST);
    assign unf_evt = do_pop && (state_q.ptr == PTR_EMPTY);
    assign fault_evt = state_q.fault_cfg && (ovf_evt || unf_evt);

    always_comb begin
        set_flags = '0;
        set_flags[FLAG_OVERFLOW] = ovf_evt;
        set_flags[FLAG_UNDERFLOW] = unf_evt;
        clr_flags = '0;
        if (wr_take && paddr == OFF_INT_CLEAR) begin
            clr_flags = pwdata[FLAG_COUNT-1:0];
        end
    end

    always_comb begin
        state_d = state_q;
        state_d.ret_valid = 1'b0;
        state_d.fault_reset = 1'b0;
        // software side of the bus; the core's own events follow and win
        if (access) begin
            state_d.ready = 1'b1;
            state_d.slverr = !known_addr(paddr);
            state_d.rdata = '0;
            if (!pwrite) begin
                case (paddr)
                    OFF_STACK_POINTER:
                        state_d.rdata[PTR_WIDTH-1:0] = state_q.ptr;
                    OFF_TOP_ENTRY_HIGH:
                        state_d.rdata[HIGH_WIDTH-1:0] =
                            top_val[WIDTH-1:LOW_WIDTH];
                    OFF_TOP_ENTRY_LOW:
                        state_d.rdata[LOW_WIDTH-1:0] =
                            top_val[LOW_WIDTH-1:0];
                    OFF_CONFIG:
                        state_d.rdata[CFG_FAULT_RESET] = state_q.fault_cfg;
                    OFF_STATUS:
                        state_d.rdata[FLAG_COUNT-1:0] = state_q.flags;
                    OFF_INT_ENABLE:
                        state_d.rdata[FLAG_COUNT-1:0] = state_q.int_en;
                    default:
                        state_d.rdata = '0;
                endcase
            end
        end else begin
            state_d.ready = 1'b0;
            state_d.slverr = 1'b0;
        end
        if (wr_take) begin
            case (paddr)
                OFF_STACK_POINTER: begin
                    if (pstrb[0]) begin
                        state_d.ptr = pwdata[PTR_WIDTH-1:0];
                    end
                end
                OFF_TOP_ENTRY_HIGH: begin
                    if (pstrb[0]) begin
                        state_d.entry[idx][WIDTH-1:LOW_WIDTH] =
                            pwdata[HIGH_WIDTH-1:0];
                    end
                end
                OFF_TOP_ENTRY_LOW: begin
                    if (pstrb[0]) begin
                        state_d.entry[idx][LOW_WIDTH-1:0] =
                            pwdata[LOW_WIDTH-1:0];
                    end
                end
                OFF_CONFIG: begin
                    if (pstrb[0]) begin
                        state_d.fault_cfg = pwdata[CFG_FAULT_RESET];
                    end
                end
                OFF_INT_ENABLE: begin
                    if (pstrb[0]) begin
                        state_d.int_en = pwdata[FLAG_COUNT-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // core side; the upper PC latch is outside and never written
        if (fault_evt) begin
            state_d.ptr = PTR_EMPTY;
            state_d.fault_reset = 1'b1;
        end else if (do_push) begin
            // increment first, then store; wraps as a ring
            state_d.ptr = state_q.ptr + 5'h01;
            state_d.entry[state_d.ptr[IDX_WIDTH-1:0]] = push_pc;
        end else if (do_pop) begin
            state_d.ret_pc = top_val;
            state_d.ret_valid = 1'b1;
            state_d.ptr = state_q.ptr - 5'h01;
        end
        // set beats clear in the same cycle
        state_d.flags = (state_q.flags & ~clr_flags) | set_flags;
        // level follows the enables written in this same cycle
        state_d.irq = |(state_d.flags & state_d.int_en);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
            state_q.ptr <= PTR_EMPTY;
            state_q.flags <= FLAGS_RESET_VALUE;
            state_q.fault_cfg <= CFG_RESET_VALUE;
        end else begin
            state_q <= state_d;
        end
    end

    assign prdata = state_q.rdata;
    assign pready = state_q.ready;
    assign pslverr = state_q.slverr;
    assign ret_pc = state_q.ret_pc;
    assign ret_valid = state_q.ret_valid;
    assign fault_reset = state_q.fault_reset;
    assign irq = state_q.irq;

    a_push_incr: assert property (
        @(posedge pclk) disable iff (!presetn)
        push && !fault_evt |=> state_q.ptr == $past(state_q.ptr) + 5'h01)
        else $error("push did not increment pointer");

    a_push_store: assert property (
        @(posedge pclk) disable iff (!presetn)
        push && !fault_evt |=>
            state_q.entry[state_q.ptr[IDX_WIDTH-1:0]] == $past(push_pc))
        else $error("pushed pc not stored at new top");

    a_pop_value: assert property (
        @(posedge pclk) disable iff (!presetn)
        pop && !push && !fault_evt |=> ret_valid
            && ret_pc == $past(top_val)
            && state_q.ptr == $past(state_q.ptr) - 5'h01)
        else $error("pop returned wrong value or pointer");

    a_ovf_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        push && state_q.ptr == PTR_LAST |=> state_q.flags[FLAG_OVERFLOW])
        else $error("overflow flag not set");

    a_unf_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        pop && !push && state_q.ptr == PTR_EMPTY
            |=> state_q.flags[FLAG_UNDERFLOW])
        else $error("underflow flag not set");

    a_fault_reset: assert property (
        @(posedge pclk) disable iff (!presetn)
        fault_evt |=> fault_reset && state_q.ptr == PTR_EMPTY
            ##1 !fault_reset)
        else $error("fault reset not one pulse");

    a_ring_wrap: assert property (
        @(posedge pclk) disable iff (!presetn)
        push && !state_q.fault_cfg && state_q.ptr == PTR_LAST
            |=> state_q.entry[0] == $past(push_pc))
        else $error("ring mode did not overwrite entry zero");

    // with the fault reset off a fault sets its flag, the push or pop still goes ahead and no fault_reset is raised
    a_no_fault_ring: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ovf_evt || unf_evt) && !state_q.fault_cfg |=> !fault_reset)
        else $error("fault reset raised while disabled");

    a_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq == |(state_q.flags & state_q.int_en))
        else $error("interrupt level wrong");

    a_apb_wait: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("slave did not answer in one cycle");

    a_err_rdata: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready && pslverr |-> prdata == 32'h0)
        else $error("unmapped access returned data");

    a_ptr_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_take && paddr == OFF_STACK_POINTER && pstrb[0] && !push && !pop
            |=> state_q.ptr == $past(pwdata[PTR_WIDTH-1:0]))
        else $error("pointer write did not land");

    // all register bits sit in lane zero, so lane zero gates every write except the interrupt clear
    a_strb_mask: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_take && !pstrb[0] && !push && !pop
            |=> $stable(state_q.ptr) && $stable(state_q.entry))
        else $error("write with lane zero off changed the stack");

    // the returned pc stands until the next return
    a_ret_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !pop |=> $stable(ret_pc))
        else $error("popped pc changed without a pop");

    c_overflow: cover property (@(posedge pclk) disable iff (!presetn)
        ovf_evt);
    c_underflow: cover property (@(posedge pclk) disable iff (!presetn)
        unf_evt);
    c_fault: cover property (@(posedge pclk) disable iff (!presetn)
        fault_evt);
    c_top_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr_take && paddr == OFF_TOP_ENTRY_LOW);
    c_ring: cover property (@(posedge pclk) disable iff (!presetn)
        push && !state_q.fault_cfg && state_q.ptr == PTR_LAST);
endmodule : return_address_stack

// [verilog/ras_pkg.sv]
/*
 * Constants for the return-address stack: depth, widths, register map
 * and field positions.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package ras_pkg;
    localparam int STACK_DEPTH = 16;
    localparam int PC_WIDTH = 15;
    localparam int PTR_WIDTH = 5;
    localparam int IDX_WIDTH = 4;
    localparam int ADDR_WIDTH = 8;
    localparam int LOW_WIDTH = 8;
    localparam int HIGH_WIDTH = PC_WIDTH - LOW_WIDTH;

    localparam logic [ADDR_WIDTH-1:0] OFF_STACK_POINTER = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] OFF_TOP_ENTRY_HIGH = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] OFF_TOP_ENTRY_LOW = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] OFF_CONFIG = 8'h0C;
    localparam logic [ADDR_WIDTH-1:0] OFF_STATUS = 8'h10;
    localparam logic [ADDR_WIDTH-1:0] OFF_INT_CLEAR = 8'h14;
    localparam logic [ADDR_WIDTH-1:0] OFF_INT_ENABLE = 8'h18;

    // empty stack: pointer sits one below entry zero
    localparam logic [PTR_WIDTH-1:0] PTR_EMPTY = 5'h1F;
    localparam logic [PTR_WIDTH-1:0] PTR_LAST = 5'h0F;

    localparam int FLAG_OVERFLOW = 0;
    localparam int FLAG_UNDERFLOW = 1;
    localparam int FLAG_COUNT = 2;
    localparam int CFG_FAULT_RESET = 0;
    localparam logic CFG_RESET_VALUE = 1'b0;
    localparam logic [FLAG_COUNT-1:0] FLAGS_RESET_VALUE = 2'h0;
endpackage : ras_pkg

// [bench/core_sequencer.sv]
/*
 * Partner model of the core's instruction sequencer: one-cycle push and
 * pop events. Assumes pclk comes from the bench, which calls the tasks.
 */
module core_sequencer
    import ras_pkg::*;
(
    input wire logic pclk,
    output logic push,
    output logic [PC_WIDTH-1:0] push_pc,
    output logic pop
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        push = 1'b0;
        push_pc = 15'h0;
        pop = 1'b0;
    end

    // call, indirect jump or interrupt vectoring; pc is scrambled after
    task send_push(input logic [PC_WIDTH-1:0] pc);
        @(posedge pclk);
        push <= 1'b1;
        push_pc <= pc;
        @(posedge pclk);
        push <= 1'b0;
        push_pc <= ~pc;
    endtask : send_push

    // any of the three return kinds
    task send_pop();
        @(posedge pclk);
        pop <= 1'b1;
        @(posedge pclk);
        pop <= 1'b0;
    endtask : send_pop
endmodule : core_sequencer

// [bench/tb_return_address_stack.sv]
/*
 * Self-checking bench: APB master, sequencer model and integer model.
 * Assumes ras_pkg and core_sequencer are compiled before this file.
 */
module tb_return_address_stack
    import ras_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, push, pop, ret_valid;
    logic fault_reset, irq, err;
    logic [3:0] pstrb = 4'hF;
    logic [ADDR_WIDTH-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [PC_WIDTH-1:0] push_pc, ret_pc;
    int mismatches = 0, compares = 0, ptr = 31, flags = 0, v;
    int ent[16];

    always #5 pclk = ~pclk;

    return_address_stack dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .push(push), .push_pc(push_pc), .pop(pop), .ret_pc(ret_pc),
        .ret_valid(ret_valid), .fault_reset(fault_reset), .irq(irq));
    core_sequencer seq (.pclk(pclk), .push(push), .push_pc(push_pc),
        .pop(pop));

    task give_verdict();
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, s);
            mismatches++;
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            mismatches++;
            give_verdict();
        end
    endtask : apb

    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", e, rd);
        chk("pslverr", 32'h0, {31'h0, err});
    endtask : rdchk

    task irqchk(input logic e);
        @(posedge pclk);
        #1;
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : irqchk

    task mpush(input logic [PC_WIDTH-1:0] pc);
        seq.send_push(pc);
        if (ptr == 15) flags |= 1;
        ptr = (ptr + 1) % 32;
        ent[ptr % 16] = pc;
    endtask : mpush

    task mpop();
        seq.send_pop();
        #1;
        chk("ret_valid", 32'h1, {31'h0, ret_valid});
        chk("ret_pc", ent[ptr % 16], {17'h0, ret_pc});
        if (ptr == 31) flags |= 2;
        ptr = (ptr + 31) % 32;
    endtask : mpop

    initial begin
        void'($urandom(76));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(OFF_STACK_POINTER, 32'h1F);
        rdchk(OFF_CONFIG, 32'h0);
        rdchk(OFF_STATUS, 32'h0);
        for (int i = 0; i < 17; i++) begin
            mpush(15'($urandom));
            if (i == 15) rdchk(OFF_STACK_POINTER, ptr);
        end
        rdchk(OFF_STACK_POINTER, ptr);
        rdchk(OFF_STATUS, flags);
        for (int i = 0; i < 18; i++) mpop();
        rdchk(OFF_STATUS, flags);
        apb(1'b1, OFF_INT_ENABLE, 32'h3);
        irqchk(1'b1);
        apb(1'b1, OFF_INT_CLEAR, 32'h1);
        rdchk(OFF_STATUS, 32'h2);
        apb(1'b1, OFF_INT_ENABLE, 32'h1);
        irqchk(1'b0);
        apb(1'b1, OFF_STATUS, 32'h3);
        apb(1'b1, OFF_INT_CLEAR, 32'h2);
        rdchk(OFF_STATUS, 32'h0);
        v = $urandom % 32768;
        apb(1'b1, OFF_STACK_POINTER, 32'h5);
        apb(1'b1, OFF_TOP_ENTRY_HIGH, v >> 8);
        apb(1'b1, OFF_TOP_ENTRY_LOW, v & 255);
        rdchk(OFF_TOP_ENTRY_HIGH, v >> 8);
        rdchk(OFF_TOP_ENTRY_LOW, v & 255);
        ptr = 5;
        ent[5] = v;
        mpop();
        rdchk(OFF_STACK_POINTER, 32'h4);
        pstrb <= 4'h0;
        apb(1'b1, OFF_STACK_POINTER, 32'h9);
        pstrb <= 4'hF;
        rdchk(OFF_STACK_POINTER, 32'h4);
        apb(1'b0, 8'h1C, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("prdata", 32'h0, rd);
        apb(1'b1, OFF_CONFIG, 32'h1);
        apb(1'b1, OFF_STACK_POINTER, 32'hF);
        seq.send_push(15'h1234);
        #1;
        chk("fault_reset", 32'h1, {31'h0, fault_reset});
        @(posedge pclk);
        #1;
        chk("fault_reset", 32'h0, {31'h0, fault_reset});
        rdchk(OFF_STACK_POINTER, 32'h1F);
        rdchk(OFF_STATUS, 32'h1);
        give_verdict();
    end
endmodule : tb_return_address_stack
